// ===== hdl/protection_setup_monitor.sv
// extended protection setup word, shut-down monitor, reset masking and oscillator watchdog
`timescale 1ns/1ps
`default_nettype none
// Operation
// - A four-bit selector chooses which shut-down event or identification bit drives the monitor output.
// - Latched shut-down indications clear on a low-to-high edge of sleep.
// - Codes 0000, 0001, 0010 report converter A, B, C shut-down by either overvoltage, 0011 is unused.
// - Codes 0100, 0101, 0110 report overvoltage-high, overvoltage-low and motor overcurrent shut-downs.
// - Codes 1000 to 1010 give revision bits 0 to 2, 1011 the vendor flag, 1100 to 1111 unused.
// - Shut-down codes report events only after the dead-zone filter.
// - Mask bits 7, 6, 5 disable thermal, motor overcurrent and converter overvoltage shut-down.
// - With a reset mask bit low, that converter's shut-down pulls reset low and stops all converters.
// - With a reset mask bit high, that converter's shut-down gives no reset and the others keep running.
// - A converter stopped under a high reset mask restarts on a low-to-high edge of sleep.
// - Reset mask bits 10, 9, 8 belong to converters A, B, C and default low.
// - The two-bit warning field sets the temperature warning threshold, 11 being analog test mode.
// - The oscillator watchdog is off after power-up and runs only once its enable bit is written high.
// - When enabled the watchdog shuts the device down if the converter clock leaves 1/64 to 1/2 of the chop clock.
module protection_setup_monitor (
    input wire logic i_clk,             // system clock
    input wire logic i_rst,             // power-on reset, sync, active high
    input wire logic i_sleep,           // sleep input
    input wire logic i_setup_select,    // setup-select input
    input wire logic i_load,            // one-cycle strobe: setup word presented
    input wire logic [15:0] i_setup_data, // setup word from the shift register
    input wire logic [2:0] i_ov_high,   // converter_overvoltage_high, per channel a,b,c
    input wire logic [2:0] i_ov_low,    // converter_overvoltage_low, per channel a,b,c
    input wire logic i_motor_oc,        // motor_overcurrent raw
    input wire logic i_thermal,         // thermal_shutdown raw
    input wire logic i_chop_osc,        // motor_chop_oscillator level
    input wire logic i_conv_osc,        // converter_oscillator level
    output logic o_monitor,             // selected shut-down / id bit
    output logic o_system_reset_n,      // system_reset_output, active low
    output logic [2:0] o_conv_enable,   // converter channel run enables a,b,c
    output logic o_motor_enable,        // motor drive run enable
    output logic [1:0] o_early_thermal_warning, // threshold select for warning comparator
    output logic o_warn_analog          // warning pin in analog test mode
);
    logic [15:0] setup_q;
    logic sleep_q;
    logic wake;
    logic [2:0] conv_raw;
    logic [2:0] conv_filt;
    logic ovh_filt, ovl_filt, moc_filt, thm_filt;
    logic [2:0] conv_sd_q;   // latched per-channel converter shut-down
    logic ovh_q, ovl_q, moc_q, thm_q, wd_q;
    logic [2:0] rmask;
    logic global_sd;
    logic mon_d;
    logic mon_q;
    logic chop_q, conv_q;
    logic [7:0] win_q;
    logic [8:0] edges_q;
    logic wd_trip;

    // setup word load; window outside sleep-low/select-high is ignored
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            setup_q <= prot_pkg::SETUP_RESET;
        end else if (i_load && !i_sleep && i_setup_select) begin
            setup_q <= i_setup_data;
        end
    end

    // sleep edge detect
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= i_sleep;
        end
    end
    assign wake = i_sleep && !sleep_q;

    assign rmask = {setup_q[prot_pkg::RMASK_C_BIT], setup_q[prot_pkg::RMASK_B_BIT],
                    setup_q[prot_pkg::RMASK_A_BIT]};

    // raw events gated by their shut-down masks
    assign conv_raw = (i_ov_high | i_ov_low) & {3{!setup_q[prot_pkg::MASK_CONV_BIT]}};

    // one filter per converter channel
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_conv
            deadzone_filter u_flt (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_raw(conv_raw[g]),
                .o_filt(conv_filt[g])
            );
        end
    endgenerate

    deadzone_filter u_ovh (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_raw((|i_ov_high) && !setup_q[prot_pkg::MASK_CONV_BIT]),
        .o_filt(ovh_filt)
    );
    deadzone_filter u_ovl (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_raw((|i_ov_low) && !setup_q[prot_pkg::MASK_CONV_BIT]),
        .o_filt(ovl_filt)
    );
    deadzone_filter u_moc (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_raw(i_motor_oc && !setup_q[prot_pkg::MASK_MOTOR_BIT]),
        .o_filt(moc_filt)
    );
    deadzone_filter u_thm (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_raw(i_thermal && !setup_q[prot_pkg::MASK_THERM_BIT]),
        .o_filt(thm_filt)
    );

    // latched converter shut-downs; a new event wins over the wake clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            conv_sd_q <= 3'h0;
        end else begin
            conv_sd_q <= (wake ? 3'h0 : conv_sd_q) | conv_filt;
        end
    end

    // latched source indications
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ovh_q <= 1'b0;
            ovl_q <= 1'b0;
            moc_q <= 1'b0;
            thm_q <= 1'b0;
            wd_q <= 1'b0;
        end else begin
            ovh_q <= (ovh_q && !wake) || ovh_filt;
            ovl_q <= (ovl_q && !wake) || ovl_filt;
            moc_q <= (moc_q && !wake) || moc_filt;
            thm_q <= (thm_q && !wake) || thm_filt;
            wd_q <= (wd_q && !wake) || wd_trip;
        end
    end

    // unmasked converter shut-down stops everything; masked one stops only its own
    assign global_sd = |(conv_sd_q & ~rmask);
    assign o_system_reset_n = !global_sd;
    assign o_conv_enable = (global_sd || thm_q || moc_q || wd_q) ? 3'h0 : ~conv_sd_q;
    assign o_motor_enable = !(global_sd || thm_q || moc_q || wd_q);

    // monitor selector
    always_comb begin
        mon_d = 1'b0;
        unique case (setup_q[prot_pkg::SEL_MSB:prot_pkg::SEL_LSB])
            prot_pkg::SEL_CONV_A: mon_d = conv_sd_q[0];
            prot_pkg::SEL_CONV_B: mon_d = conv_sd_q[1];
            prot_pkg::SEL_CONV_C: mon_d = conv_sd_q[2];
            prot_pkg::SEL_OV_HIGH: mon_d = ovh_q;
            prot_pkg::SEL_OV_LOW: mon_d = ovl_q;
            prot_pkg::SEL_MOTOR_OC: mon_d = moc_q;
            prot_pkg::SEL_THERMAL: mon_d = thm_q;
            prot_pkg::SEL_REV0: mon_d = prot_pkg::REVISION_CODE[0];
            prot_pkg::SEL_REV1: mon_d = prot_pkg::REVISION_CODE[1];
            prot_pkg::SEL_REV2: mon_d = prot_pkg::REVISION_CODE[2];
            prot_pkg::SEL_VENDOR: mon_d = prot_pkg::VENDOR_FLAG;
            default: mon_d = 1'b0; // unused codes read low
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mon_q <= 1'b0;
        end else begin
            mon_q <= mon_d;
        end
    end
    assign o_monitor = mon_q;

    // warning threshold; codes 01 and 10 both mean 30 degrees below in the comparator
    assign o_early_thermal_warning = setup_q[prot_pkg::WARN_MSB:prot_pkg::WARN_LSB];
    assign o_warn_analog = (o_early_thermal_warning == prot_pkg::WARN_ANALOG);

    // oscillator edge sampling; both oscillators are slow against i_clk
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            chop_q <= 1'b0;
            conv_q <= 1'b0;
        end else begin
            chop_q <= i_chop_osc;
            conv_q <= i_conv_osc;
        end
    end

    // ratio watchdog: count converter edges over a window of chop edges
    always_ff @(posedge i_clk) begin
        if (i_rst || !setup_q[prot_pkg::WDOG_EN_BIT]) begin
            win_q <= 8'h00;
            edges_q <= 9'h000;
        end else if (i_chop_osc && !chop_q && win_q == prot_pkg::WD_WINDOW - 8'h01) begin
            win_q <= 8'h00;
            edges_q <= 9'h000;
        end else begin
            if (i_chop_osc && !chop_q) begin
                win_q <= win_q + 8'h01;
            end
            if (i_conv_osc && !conv_q && edges_q != 9'h1ff) begin
                edges_q <= edges_q + 9'h001;
            end
        end
    end

    // trip at window end if the count lies outside the limits, or overflows early
    assign wd_trip = setup_q[prot_pkg::WDOG_EN_BIT] && (
        (i_chop_osc && !chop_q && win_q == prot_pkg::WD_WINDOW - 8'h01 &&
         (edges_q < prot_pkg::WD_MIN_EDGES || edges_q > prot_pkg::WD_MAX_EDGES)) ||
        edges_q > prot_pkg::WD_MAX_EDGES);
endmodule
`default_nettype wire

// ===== pkg/prot_pkg.sv
// constants for the protection setup and monitor block
package prot_pkg;
    // setup word field positions
    localparam int SEL_LSB = 0;
    localparam int SEL_MSB = 3;
    localparam int MASK_CONV_BIT = 5;
    localparam int MASK_MOTOR_BIT = 6;
    localparam int MASK_THERM_BIT = 7;
    localparam int RMASK_C_BIT = 8;
    localparam int RMASK_B_BIT = 9;
    localparam int RMASK_A_BIT = 10;
    localparam int WARN_LSB = 11;
    localparam int WARN_MSB = 12;
    localparam int WDOG_EN_BIT = 14;
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    // selector codes
    localparam logic [3:0] SEL_CONV_A = 4'h0;
    localparam logic [3:0] SEL_CONV_B = 4'h1;
    localparam logic [3:0] SEL_CONV_C = 4'h2;
    localparam logic [3:0] SEL_OV_HIGH = 4'h4;
    localparam logic [3:0] SEL_OV_LOW = 4'h5;
    localparam logic [3:0] SEL_MOTOR_OC = 4'h6;
    localparam logic [3:0] SEL_THERMAL = 4'h7;
    localparam logic [3:0] SEL_REV0 = 4'h8;
    localparam logic [3:0] SEL_REV1 = 4'h9;
    localparam logic [3:0] SEL_REV2 = 4'ha;
    localparam logic [3:0] SEL_VENDOR = 4'hb;
    // identification values, arbitrary
    localparam logic [2:0] REVISION_CODE = 3'h5;
    localparam logic VENDOR_FLAG = 1'b0;
    // warning threshold encodings
    localparam logic [1:0] WARN_MINUS20 = 2'h0;
    localparam logic [1:0] WARN_ANALOG = 2'h3;
    // dead-zone filter length in clock cycles
    localparam int FILTER_NS = 50;
    localparam int CLK_NS = 10;
    localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    // watchdog window in chop-oscillator cycles, and converter edge limits
    localparam logic [7:0] WD_WINDOW = 8'h80;
    localparam logic [8:0] WD_MIN_EDGES = 9'h002;  // window / 64
    localparam logic [8:0] WD_MAX_EDGES = 9'h040;  // window / 2
endpackage

// ===== hdl/deadzone_filter.sv
// dead-zone filter: output follows input once stable for FILTER_CYC cycles
`timescale 1ns/1ps
`default_nettype none
module deadzone_filter (
    input wire logic i_clk,   // system clock
    input wire logic i_rst,   // sync reset, active high
    input wire logic i_raw,   // unfiltered event level
    output logic o_filt       // filtered event level
);
    logic [3:0] cnt_q;
    logic filt_q;

    // count cycles the raw level differs from the output; short glitches vanish
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 4'h0;
            filt_q <= 1'b0;
        end else if (i_raw == filt_q) begin
            cnt_q <= 4'h0;
        end else if (cnt_q == 4'(prot_pkg::FILTER_CYC - 1)) begin
            cnt_q <= 4'h0;
            filt_q <= i_raw;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    assign o_filt = filt_q;
endmodule
`default_nettype wire

// ===== dv/host_model.sv
// host controller model that loads protection setup words
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic i_clk,     // system clock
    output logic o_load,        // one-cycle load strobe
    output logic [15:0] o_data  // setup word
);
    // idle data is the inverse of the last word so stale bits never pass for fresh ones
    initial begin
        o_load = 1'b0;
        o_data = 16'h0000;
    end
    // one load: strobe and word held across one rising edge, then released
    task automatic put(input logic [15:0] word);
        @(negedge i_clk);
        o_data = word;
        o_load = 1'b1;
        @(negedge i_clk);
        o_load = 1'b0;
        o_data = ~word;
    endtask
endmodule
`default_nettype wire

// ===== dv/protection_setup_monitor_assertions.sv
// concurrent checks for the protection setup and monitor block
`timescale 1ns/1ps
`default_nettype none
module protection_setup_monitor_assertions (
    input wire logic i_clk,                        // clock
    input wire logic i_rst,                        // reset
    input wire logic i_sleep,                      // sleep
    input wire logic i_setup_select,               // setup select
    input wire logic i_load,                       // load strobe
    input wire logic [15:0] i_setup_data,          // setup word
    input wire logic [2:0] i_ov_high,              // overvoltage high
    input wire logic [2:0] i_ov_low,               // overvoltage low
    input wire logic i_motor_oc,                   // motor overcurrent
    input wire logic i_thermal,                    // thermal
    input wire logic i_chop_osc,                   // chop oscillator
    input wire logic i_conv_osc,                   // converter oscillator
    input wire logic o_monitor,                    // monitor
    input wire logic o_system_reset_n,             // system reset
    input wire logic [2:0] o_conv_enable,          // converter enables
    input wire logic o_motor_enable,               // motor enable
    input wire logic [1:0] o_early_thermal_warning, // warning field
    input wire logic o_warn_analog                 // analog mode
);
    logic [15:0] cfg_q;
    logic take;
    logic quiet;
    assign take = i_load && !i_sleep && i_setup_select;
    assign quiet = i_ov_high == 3'h0 && i_ov_low == 3'h0 && !i_motor_oc && !i_thermal;
    // shadow of the setup word so the checks know masks and selector
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_q <= 16'h0000;
        end else if (take) begin
            cfg_q <= i_setup_data;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence wake;
        !i_sleep ##1 i_sleep;
    endsequence
    AST_WARN: assert property (take |=> o_early_thermal_warning == cfg_q[12:11])
        else $error("warning field differs from loaded word");
    AST_REFUSE: assert property (i_load && !take |=> $stable(o_early_thermal_warning))
        else $error("refused load changed the setup");
    AST_RST_OFF: assert property (!o_system_reset_n |-> o_conv_enable == 3'h0)
        else $error("converter running during system reset");
    AST_WAKE: assert property (quiet[*6] ##0 wake
        |-> ##[1:2] (o_system_reset_n && o_conv_enable == 3'h7)) else $error("wake kept stop");
    AST_THERM: assert property ((!cfg_q[7] && i_thermal)[*7]
        |-> ##[0:2] !o_motor_enable) else $error("thermal shut-down not applied");
    AST_CONV_RESET: assert property ((!cfg_q[5] && !cfg_q[10] && i_ov_high[0])[*7]
        |-> ##[0:2] !o_system_reset_n) else $error("reset not driven low");
    AST_RST_CAUSE: assert property ($fell(o_system_reset_n)
        |-> !cfg_q[5] && !(cfg_q[10] && cfg_q[9] && cfg_q[8])) else $error("masked reset");
    AST_UNUSED: assert property ((cfg_q[3:0] == 4'h3 || cfg_q[3:0] >= 4'hc)[*4]
        |-> !o_monitor) else $error("unused code drives monitor");
    AST_FILTER: assert property ((cfg_q[3:0] == 4'h7 && !o_monitor && !i_thermal)
        ##1 i_thermal[*3] |-> !o_monitor) else $error("short event passed the filter");
endmodule
bind protection_setup_monitor protection_setup_monitor_assertions chk (.i_clk(i_clk),
    .i_rst(i_rst), .i_sleep(i_sleep), .i_setup_select(i_setup_select), .i_load(i_load),
    .i_setup_data(i_setup_data), .i_ov_high(i_ov_high), .i_ov_low(i_ov_low),
    .i_motor_oc(i_motor_oc), .i_thermal(i_thermal), .i_chop_osc(i_chop_osc),
    .i_conv_osc(i_conv_osc), .o_monitor(o_monitor), .o_system_reset_n(o_system_reset_n),
    .o_conv_enable(o_conv_enable), .o_motor_enable(o_motor_enable),
    .o_early_thermal_warning(o_early_thermal_warning), .o_warn_analog(o_warn_analog));
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the protection setup and monitor block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk, i_rst, sleep, sel, moc, th, mon, rstn, men, ana, load;
    logic chop = 1'b0;
    logic conv = 1'b0;
    logic [15:0] data, w;
    logic [7:0] ev;
    logic [2:0] ovh, ovl, en, e;
    logic [1:0] warn, mr;
    logic [3:0] idv = {prot_pkg::VENDOR_FLAG, prot_pkg::REVISION_CODE};
    int failures = 0, checked = 0, half = 0, cc = 0, k;
    // word, events {ov high, ov low, motor, thermal}, {monitor, reset_n}, enables
    logic [28:0] rows [15] = '{
        {16'h0000, 8'h20, 2'h2, 3'h0}, {16'h0001, 8'h08, 2'h2, 3'h0}, {16'h0002, 8'h80, 2'h2, 3'h0},
        {16'h0000, 8'h40, 2'h0, 3'h0}, {16'h0004, 8'h20, 2'h2, 3'h0}, {16'h0005, 8'h04, 2'h2, 3'h0},
        {16'h0005, 8'h20, 2'h0, 3'h0}, {16'h0006, 8'h02, 2'h3, 3'h0}, {16'h0007, 8'h01, 2'h3, 3'h0},
        {16'h0087, 8'h01, 2'h1, 3'h7}, {16'h0046, 8'h02, 2'h1, 3'h7}, {16'h0024, 8'h20, 2'h1, 3'h7},
        {16'h0400, 8'h20, 2'h3, 3'h6}, {16'h0102, 8'h10, 2'h3, 3'h3}, {16'h0003, 8'h00, 2'h1, 3'h7}};
    protection_setup_monitor dut (.i_clk(i_clk), .i_rst(i_rst), .i_sleep(sleep),
        .i_setup_select(sel), .i_load(load), .i_setup_data(data), .i_ov_high(ovh),
        .i_ov_low(ovl), .i_motor_oc(moc), .i_thermal(th), .i_chop_osc(chop),
        .i_conv_osc(conv), .o_monitor(mon), .o_system_reset_n(rstn), .o_conv_enable(en),
        .o_motor_enable(men), .o_early_thermal_warning(warn), .o_warn_analog(ana));
    host_model host (.i_clk(i_clk), .o_load(load), .o_data(data));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // chop oscillator at four clocks; converter toggles every half clocks, zero stops it
    always @(negedge i_clk) begin
        cc <= cc + 1;
        chop <= cc[1];
        if (half != 0 && cc % half == 0) begin
            conv <= ~conv;
        end
    end
    task automatic check(input logic [3:0] exp, input logic [3:0] got);
        checked++;
        if (exp !== got) begin
            failures++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // drop events, let the filter fall, then a wake edge with sleep back low for loads
    task automatic wake();
        {ovh, ovl, moc, th} = 8'h00;
        repeat (8) @(negedge i_clk);
        sleep = 1'b1;
        repeat (2) @(negedge i_clk);
        sleep = 1'b0;
        repeat (3) @(negedge i_clk);
        check(4'h7, {1'b0, en});
        check(4'h0, {3'h0, mon});
    endtask
    // the whole run is near 4700 cycles, so 200 us means a hang
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    initial begin
        {i_rst, sleep, sel, ovh, ovl, moc, th} = 11'h500;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        for (k = 0; k < 15; k++) begin
            {w, ev, mr, e} = rows[k];
            host.put(w);
            {ovh, ovl, moc, th} = ev;
            repeat (12) @(negedge i_clk);
            check({3'h0, mr[1]}, {3'h0, mon});
            check({3'h0, mr[0]}, {3'h0, rstn});
            check({1'b0, e}, {1'b0, en});
            check({3'h0, e != 3'h0}, {3'h0, men});
            wake();
        end
        for (k = 8; k < 16; k++) begin
            host.put(16'(k));
            repeat (3) @(negedge i_clk);
            check({3'h0, k < 12 ? idv[k - 8] : 1'b0}, {3'h0, mon});
        end
        host.put(16'h0007);
        // two quiet cycles under the new code first, so the filter check has a clean start
        repeat (2) @(negedge i_clk);
        th = 1'b1;
        repeat (3) @(negedge i_clk);
        th = 1'b0;
        repeat (8) @(negedge i_clk);
        check(4'h0, {3'h0, mon});
        for (k = 0; k < 4; k++) begin
            host.put(16'(k << 11));
            check(4'(k), {2'h0, warn});
            check({3'h0, k == 3}, {3'h0, ana});
        end
        sleep = 1'b1;
        host.put(16'h0000);
        sleep = 1'b0;
        sel = 1'b0;
        host.put(16'h0000);
        sel = 1'b1;
        check(4'h3, {2'h0, warn});
        half = 8;
        host.put(16'h4000);
        repeat (1200) @(negedge i_clk);
        check(4'h7, {1'b0, en});
        check(4'h1, {3'h0, men});
        half = 0;
        repeat (1200) @(negedge i_clk);
        check(4'h0, {1'b0, en});
        check(4'h0, {3'h0, men});
        i_rst = 1'b1;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        check(4'h1, {3'h0, rstn});
        half = 1;
        repeat (1200) @(negedge i_clk);
        check(4'h7, {1'b0, en});
        host.put(16'h4000);
        repeat (600) @(negedge i_clk);
        check(4'h0, {1'b0, en});
        wrap_up();
    end
endmodule
`default_nettype wire
